// File: i2ccp_slave.sv
/*
  Two-wire control port slave of the audio processor with mode selection.
  Assumes open-drain SDA/SCL resolved outside, a memory map answering the
  subaddress decode combinationally and read data valid one cycle after
  rd_req.
*/
`timescale 1ns/1ns
module i2ccp_slave
  import i2ccp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output      logic        sda_out,
  output      logic        sda_oe_n,
  // Straps and latch
  input  wire logic        boot_source_select_pin,
  input  wire logic        serial_latch_pin,
  input  wire logic        bus_addr_select_lo,
  input  wire logic        bus_addr_select_hi,
  // Mode
  output      i2ccp_mode_t mode,
  output      logic        boot_start,
  // Memory side
  output      logic [15:0] map_addr,
  input  wire i2ccp_map_t  map_info,
  output      i2ccp_wr_t   wr,
  output      logic        rd_req,
  output      logic [2:0]  rd_index,
  input  wire logic [7:0]  rd_data
);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  // Three stages; a change counts once stages two and three agree
  logic [2:0] scl_s_r, sda_s_r, lat_s_r, scl_s_nxt, sda_s_nxt, lat_s_nxt;
  logic       scl_q_r, sda_q_r, lat_q_r, scl_q_nxt, sda_q_nxt, lat_q_nxt;

  always_comb begin
    scl_s_nxt = {scl_s_r[1:0], scl_in};
    sda_s_nxt = {sda_s_r[1:0], sda_in};
    lat_s_nxt = {lat_s_r[1:0], serial_latch_pin};
    scl_q_nxt = (scl_s_r[2] == scl_s_r[1]) ? scl_s_r[2] : scl_q_r;
    sda_q_nxt = (sda_s_r[2] == sda_s_r[1]) ? sda_s_r[2] : sda_q_r;
    lat_q_nxt = (lat_s_r[2] == lat_s_r[1]) ? lat_s_r[2] : lat_q_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      lat_s_r <= 3'h7;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      lat_q_r <= 1'b1;
    end else if (clk_en) begin
      scl_s_r <= scl_s_nxt;
      sda_s_r <= sda_s_nxt;
      lat_s_r <= lat_s_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      lat_q_r <= lat_q_nxt;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c, lat_fall;
  assign scl_rise = scl_q_nxt & ~scl_q_r;
  assign scl_fall = ~scl_q_nxt & scl_q_r;
  assign start_c  = scl_q_r & scl_q_nxt & sda_q_r & ~sda_q_nxt;
  assign stop_c   = scl_q_r & scl_q_nxt & ~sda_q_r & sda_q_nxt;
  assign lat_fall = ~lat_q_nxt & lat_q_r;

  // ***************************************************************
  // Control mode
  // ***************************************************************
  // Strap caught by a clocked process on the first enabled cycle after reset
  i2ccp_mode_t mode_r, mode_nxt;
  logic        strap_done_r, strap_done_nxt;
  logic [1:0]  lat_cnt_r, lat_cnt_nxt;
  logic        boot_r, boot_nxt;

  always_comb begin
    mode_nxt       = mode_r;
    strap_done_nxt = 1'b1;
    lat_cnt_nxt    = lat_cnt_r;
    boot_nxt       = 1'b0;
    if (!strap_done_r) begin
      if (boot_source_select_pin) begin
        mode_nxt = I2CCP_MODE_BOOT;
        boot_nxt = 1'b1;
      end else begin
        mode_nxt = I2CCP_MODE_I2C;
      end
    end else if (mode_r == I2CCP_MODE_I2C && lat_fall) begin
      lat_cnt_nxt = lat_cnt_r + 2'h1;
      if (lat_cnt_nxt == I2CCP_LATCH_PULSES)
        mode_nxt = I2CCP_MODE_SPI;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_r       <= I2CCP_MODE_I2C;
      strap_done_r <= 1'b0;
      lat_cnt_r    <= 2'h0;
      boot_r       <= 1'b0;
    end else if (clk_en) begin
      mode_r       <= mode_nxt;
      strap_done_r <= strap_done_nxt;
      lat_cnt_r    <= lat_cnt_nxt;
      boot_r       <= boot_nxt;
    end
  end

  assign mode       = mode_r;
  assign boot_start = boot_r;

  // ***************************************************************
  // Slave engine
  // ***************************************************************
  i2ccp_state_t st_r, st_nxt, ret_r, ret_nxt;
  logic [7:0]   sh_r, sh_nxt;
  logic [3:0]   bit_r, bit_nxt;
  logic [15:0]  sub_r, sub_nxt;
  logic [2:0]   idx_r, idx_nxt;
  logic         ack_r, ack_nxt;       // Drive ninth bit low
  logic         rdrv_r, rdrv_nxt;     // Driving read data
  logic         top_r, top_nxt;       // Highest location reached; further writes refused
  i2ccp_wr_t    wr_r, wr_nxt;
  logic         rreq_r, rreq_nxt;
  logic         sda_o_r, sda_o_nxt;
  logic         active;

  assign active   = strap_done_r && mode_r == I2CCP_MODE_I2C;
  assign map_addr = sub_r;

  always_comb begin
    st_nxt    = st_r;
    ret_nxt   = ret_r;
    sh_nxt    = sh_r;
    bit_nxt   = bit_r;
    sub_nxt   = sub_r;
    idx_nxt   = idx_r;
    ack_nxt   = ack_r;
    rdrv_nxt  = rdrv_r;
    top_nxt   = top_r;
    wr_nxt    = '0;
    rreq_nxt  = 1'b0;
    sda_o_nxt = sda_o_r;
    if (!active || stop_c) begin
      st_nxt    = I2CCP_ST_IDLE;
      ack_nxt   = 1'b0;
      rdrv_nxt  = 1'b0;
      sda_o_nxt = 1'b1;
    end else if (start_c) begin
      // Start anywhere, repeated or out of sequence, restarts addressing
      st_nxt    = I2CCP_ST_ADDR;
      bit_nxt   = 4'h0;
      ack_nxt   = 1'b0;
      rdrv_nxt  = 1'b0;
      sda_o_nxt = 1'b1;
    end else begin
      unique case (st_r)
        I2CCP_ST_IDLE: begin
          sda_o_nxt = 1'b1;
        end
        I2CCP_ST_ADDR, I2CCP_ST_SUBHI, I2CCP_ST_SUBLO,
        I2CCP_ST_WDATA: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_q_r};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == I2CCP_BITS_PER_BYTE) begin
            bit_nxt = 4'h0;
            ret_nxt = st_r;
            st_nxt  = I2CCP_ST_ACK;
            ack_nxt = 1'b0;
            unique case (st_r)
              I2CCP_ST_ADDR: begin
                if (sh_r[7:3] == I2CCP_ADDR_PREFIX &&
                    sh_r[2] == bus_addr_select_hi &&
                    sh_r[1] == bus_addr_select_lo) begin
                  ack_nxt  = 1'b1;
                  rdrv_nxt = sh_r[0];
                  idx_nxt  = 3'h0;
                  top_nxt  = 1'b0;
                  rreq_nxt = sh_r[0];
                end else begin
                  st_nxt = I2CCP_ST_IDLE;
                end
              end
              I2CCP_ST_SUBHI: begin
                sub_nxt[15:8] = sh_r;
                ack_nxt       = 1'b1;
              end
              I2CCP_ST_SUBLO: begin
                sub_nxt[7:0] = sh_r;
                idx_nxt      = 3'h0;
                ack_nxt      = 1'b1;
              end
              default: begin
                if (map_info.valid) begin
                  // Read-only targets drop the byte but still acknowledge
                  wr_nxt.valid = ~map_info.ro;
                  wr_nxt.addr  = sub_r;
                  wr_nxt.index = idx_r;
                  wr_nxt.data  = sh_r;
                  ack_nxt      = 1'b1;
                  if (idx_r + 3'h1 >= map_info.wlen) begin
                    idx_nxt = 3'h0;
                    if (sub_r == I2CCP_SUB_MAX)
                      top_nxt = 1'b1;
                    else
                      sub_nxt = sub_r + 16'h0001;
                  end else begin
                    idx_nxt = idx_r + 3'h1;
                  end
                  if (top_r) begin
                    wr_nxt.valid = 1'b0;
                    ack_nxt      = 1'b0;
                    st_nxt       = I2CCP_ST_IDLE;
                  end
                end else begin
                  st_nxt = I2CCP_ST_IDLE;
                end
              end
            endcase
            if (st_r == I2CCP_ST_SUBLO && !map_info.valid) begin
              // Decode is checked once the full subaddress is known
              ack_nxt = 1'b1;
            end
            sda_o_nxt = ~ack_nxt;
          end
        end
        I2CCP_ST_RDATA: begin
          // Bit counter runs on falls; 8 bits then master ack slot
          if (scl_fall) begin
            bit_nxt = bit_r + 4'h1;
            if (bit_r < I2CCP_BITS_PER_BYTE) begin
              sda_o_nxt = rd_data[3'h7 - bit_r[2:0]];
            end else if (bit_r == I2CCP_BITS_PER_BYTE) begin
              sda_o_nxt = 1'b1;
            end else begin
              bit_nxt   = 4'h1;
              sda_o_nxt = rd_data[7];
            end
          end
          // Request on the ack rise so data settles before the next fall
          if (scl_rise && bit_r == I2CCP_BITS_PER_BYTE + 4'h1) begin
            rreq_nxt = !sda_q_r && map_info.valid;
            if (sda_q_r) begin
              st_nxt   = I2CCP_ST_IDLE;
              rdrv_nxt = 1'b0;
            end else if (!map_info.valid) begin
              st_nxt   = I2CCP_ST_IDLE;
              rdrv_nxt = 1'b0;
            end else if (idx_r + 3'h1 >= map_info.wlen) begin
              idx_nxt = 3'h0;
              if (sub_r != I2CCP_SUB_MAX)
                sub_nxt = sub_r + 16'h0001;
              else
                top_nxt = 1'b1;
            end else begin
              idx_nxt = idx_r + 3'h1;
            end
          end
        end
        I2CCP_ST_ACK: begin
          if (scl_fall) begin
            ack_nxt   = 1'b0;
            sda_o_nxt = 1'b1;
            unique case (ret_r)
              I2CCP_ST_ADDR:
                st_nxt = rdrv_r ? I2CCP_ST_RDATA : I2CCP_ST_SUBHI;
              I2CCP_ST_SUBHI: st_nxt = I2CCP_ST_SUBLO;
              default:        st_nxt = I2CCP_ST_WDATA;
            endcase
            if (ret_r == I2CCP_ST_ADDR && rdrv_r) begin
              sda_o_nxt = rd_data[7];
              bit_nxt   = 4'h1;
            end
            if (ret_r == I2CCP_ST_SUBLO && !map_info.valid) begin
              st_nxt = I2CCP_ST_IDLE;
            end
          end
        end
        default: st_nxt = I2CCP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r    <= I2CCP_ST_IDLE;
      ret_r   <= I2CCP_ST_IDLE;
      sh_r    <= 8'h00;
      bit_r   <= 4'h0;
      sub_r   <= 16'h0000;
      idx_r   <= 3'h0;
      ack_r   <= 1'b0;
      rdrv_r  <= 1'b0;
      top_r   <= 1'b0;
      wr_r    <= '0;
      rreq_r  <= 1'b0;
      sda_o_r <= 1'b1;
    end else if (clk_en) begin
      st_r    <= st_nxt;
      ret_r   <= ret_nxt;
      sh_r    <= sh_nxt;
      bit_r   <= bit_nxt;
      sub_r   <= sub_nxt;
      idx_r   <= idx_nxt;
      ack_r   <= ack_nxt;
      rdrv_r  <= rdrv_nxt;
      top_r   <= top_nxt;
      wr_r    <= wr_nxt;
      rreq_r  <= rreq_nxt;
      sda_o_r <= sda_o_nxt;
    end
  end

  // Open drain: only a low is ever driven
  assign sda_out  = 1'b0;
  assign sda_oe_n = sda_o_r;
  assign wr       = wr_r;
  assign rd_req   = rreq_r;
  assign rd_index = idx_r;

endmodule : i2ccp_slave

// File: i2ccp_pkg.sv
/*
  Package for the two-wire control port slave: constants, states, carriers.
  Assumes a single 50 MHz clock domain and no software-visible registers.
*/
package i2ccp_pkg;

  // ***************************************************************
  // Addressing
  // ***************************************************************
  localparam logic [4:0]  I2CCP_ADDR_PREFIX = 5'h0E;   // 0111 0
  localparam logic [15:0] I2CCP_SUB_MAX     = 16'hFFFF;

  // ***************************************************************
  // Timing and counts
  // ***************************************************************
  localparam int          I2CCP_CLK_MHZ        = 50;
  localparam logic [1:0]  I2CCP_LATCH_PULSES   = 2'h3;
  localparam logic [3:0]  I2CCP_BITS_PER_BYTE  = 4'h8;
  localparam logic [2:0]  I2CCP_WLEN_RESET     = 3'h1;

  // ***************************************************************
  // Control modes
  // ***************************************************************
  typedef enum logic [2:0] {
    I2CCP_MODE_I2C  = 3'b001,
    I2CCP_MODE_SPI  = 3'b010,
    I2CCP_MODE_BOOT = 3'b100
  } i2ccp_mode_t;

  // ***************************************************************
  // Slave states
  // ***************************************************************
  typedef enum logic [6:0] {
    I2CCP_ST_IDLE  = 7'b0000001,
    I2CCP_ST_ADDR  = 7'b0000010,
    I2CCP_ST_SUBHI = 7'b0000100,
    I2CCP_ST_SUBLO = 7'b0001000,
    I2CCP_ST_WDATA = 7'b0010000,
    I2CCP_ST_RDATA = 7'b0100000,
    I2CCP_ST_ACK   = 7'b1000000
  } i2ccp_state_t;

  // ***************************************************************
  // Carriers to and from the memory side
  // ***************************************************************
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [2:0]  index;
    logic [7:0]  data;
  } i2ccp_wr_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  wlen;
    logic        ro;
  } i2ccp_map_t;

endpackage : i2ccp_pkg

// File: i2ccp_slave_chk.sv
/*
  Checker for the control port slave, bound to its top ports.
  Assumes clk_en is held high.
*/
`timescale 1ns/1ns
module i2ccp_slave_chk
  import i2ccp_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Bus
  input wire logic        scl_in,
  input wire logic        sda_oe_n,
  // Mode
  input wire logic        boot_source_select_pin,
  input wire i2ccp_mode_t mode,
  input wire logic        boot_start,
  // Memory side
  input wire i2ccp_wr_t   wr,
  input wire logic        rd_req,
  input wire logic [2:0]  rd_index,
  input wire i2ccp_map_t  map_info
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Strap effects are judged one edge after release
  sequence s_rel;
    $past(rst_n) && !$past(rst_n, 2);
  endsequence
  a_mode_strap: assert property (s_rel |-> mode ==
    ($past(boot_source_select_pin) ? I2CCP_MODE_BOOT : I2CCP_MODE_I2C))
    else $error("mode does not follow strap");
  a_boot_strap: assert property (s_rel |->
    boot_start == $past(boot_source_select_pin))
    else $error("boot pulse does not follow strap");
  a_boot_once: assert property (
    boot_start |=> (!boot_start) [*8])
    else $error("boot pulse too long");
  a_boot_mode: assert property (
    boot_start |-> mode == I2CCP_MODE_BOOT)
    else $error("boot pulse outside self-boot mode");
  a_spi_keep: assert property (
    mode == I2CCP_MODE_SPI |=> mode == I2CCP_MODE_SPI)
    else $error("four-wire mode left");
  // Outside two-wire mode the pins belong to another port
  a_bus_quiet: assert property (
    mode != I2CCP_MODE_I2C |-> sda_oe_n)
    else $error("SDA pulled outside two-wire mode");
  // Changing SDA while SCL is high would forge a start or stop
  a_sda_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in)
    else $error("SDA drive changed while SCL high");
  a_wr_acked: assert property (
    wr.valid |-> $fell(sda_oe_n))
    else $error("stored byte not acknowledged");
  a_rd_index: assert property (
    rd_req |-> rd_index < map_info.wlen)
    else $error("read index beyond word length");
  c_burst: cover property (wr.valid && wr.index == 3'h4);
  c_read: cover property (rd_req);
  c_spi: cover property ($rose(mode == I2CCP_MODE_SPI));
endmodule : i2ccp_slave_chk

bind i2ccp_slave i2ccp_slave_chk i_i2ccp_slave_chk (
  .clk_sys, .rst_n, .scl_in, .sda_oe_n, .boot_source_select_pin,
  .mode, .boot_start, .wr, .rd_req, .rd_index, .map_info
);

// File: i2ccp_master.sv
/*
  Behavioural two-wire bus master standing in for the system controller.
  Assumes the bench resolves SDA with a pull-up from sda_drv and the slave.
*/
`timescale 1ns/1ns
module i2ccp_master (
  // Clock
  input  wire logic clk_sys,
  // Bus
  output      logic scl,
  output      logic sda_drv,
  input  wire logic sda_line
);
  // Long phases keep every level well past the slave's input sync
  localparam int PH = 12;
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic drive(input logic c, input logic d);
    scl     <= c;
    sda_drv <= d;
    repeat (PH) @(posedge clk_sys);
  endtask : drive
  // One condition per SCL high period, one line moving per phase
  task automatic start;
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    drive(1'b0, b);
    drive(1'b1, b);
    r = sda_line;
    drive(1'b0, b);
  endtask : bit_x
  // MSB first, then the ninth bit; m_ack high releases SDA
  task automatic byte_x(input logic [7:0] d, input logic m_ack,
                        output logic [7:0] q, output logic s_ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(m_ack, r);
    s_ack = !r;
  endtask : byte_x
endmodule : i2ccp_master

// File: tb.sv
/*
  Self-checking bench for the control port slave with a master model.
  Assumes one 50 MHz clock and a memory map that decodes at once.
*/
`timescale 1ns/1ns
module tb
  import i2ccp_pkg::*;
;
  localparam logic [7:0] AW = {I2CCP_ADDR_PREFIX, 2'b11, 1'b0};
  logic        clk_sys, rst_n, clk_en, scl, sda_drv, sda_line, a;
  logic        boot_pin, latch, sel_lo, sel_hi, sda_out, sda_oe_n;
  logic        boot_start, rd_req;
  logic [2:0]  rd_index;
  logic [7:0]  rd_data, q;
  logic [15:0] map_addr;
  i2ccp_mode_t mode;
  i2ccp_map_t  map_info;
  i2ccp_wr_t   wr;
  i2ccp_wr_t   wq[$];
  int          n_mismatch = 0;
  int          compares = 0;

  i2ccp_slave i_i2ccp_slave (
    .clk_sys, .rst_n, .clk_en, .scl_in(scl), .sda_in(sda_line), .sda_out,
    .sda_oe_n, .boot_source_select_pin(boot_pin),
    .serial_latch_pin(latch), .bus_addr_select_lo(sel_lo),
    .bus_addr_select_hi(sel_hi), .mode, .boot_start, .map_addr,
    .map_info, .wr, .rd_req, .rd_index, .rd_data
  );
  i2ccp_master i_i2ccp_master (.clk_sys, .scl, .sda_drv, .sda_line);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ****
  // Memory side
  // ****
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  // Read data follows the held word, so it stays valid after rd_req
  assign rd_data = map_addr[7:0] ^ {5'h00, rd_index} ^ 8'hA5;
  always_comb begin
    map_info.valid = !(map_addr[15:12] inside {[4'h8:4'hE]});
    map_info.ro    = map_addr[15:12] == 4'h2;
    map_info.wlen  = (map_addr[15:12] == 4'h0) ? 3'h4 :
                     (map_addr[15:12] == 4'h1) ? 3'h5 :
                     (map_addr[15:12] == 4'hF) ? 3'h1 : 3'h2;
  end
  always @(posedge clk_sys) begin
    if (wr.valid === 1'b1) begin
      wq.push_back(wr);
    end
  end
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] s, e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic rst(input logic b);
    boot_pin <= b;
    rst_n    <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask : rst
  task automatic wb(input logic [7:0] d, input logic ea);
    i_i2ccp_master.byte_x(d, 1'b1, q, a);
    chk("slave ack", 16'(a), 16'(ea));
  endtask : wb
  task automatic hdr(input logic [15:0] sub);
    i_i2ccp_master.start();
    wb(AW, 1'b1);
    wb(sub[15:8], 1'b1);
    wb(sub[7:0], 1'b1);
  endtask : hdr
  task automatic t_addr;
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} <= 2'(s);
      i_i2ccp_master.start();
      wb({I2CCP_ADDR_PREFIX, 2'(s), 1'b0}, 1'b1);
      i_i2ccp_master.start();
      wb({I2CCP_ADDR_PREFIX, 2'(~s), 1'b0}, 1'b0);
      i_i2ccp_master.stop();
    end
    $display("address test done");
  endtask : t_addr
  task automatic t_burst;
    wq.delete();
    hdr(16'h0FFF);
    for (int k = 0; k < 9; k++) begin
      wb(8'(8'h10 + k), 1'b1);
    end
    i_i2ccp_master.stop();
    chk("write count", 16'(wq.size()), 16'h0009);
    for (int k = 0; k < 9 && k < wq.size(); k++) begin
      chk("addr", wq[k].addr, (k < 4) ? 16'h0FFF : 16'h1000);
      chk("index", 16'(wq[k].index), 16'(k < 4 ? k : k - 4));
      chk("data", 16'(wq[k].data), 16'(8'h10 + k));
    end
    $display("burst write done");
  endtask : t_burst
  task automatic t_refuse(input logic [15:0] sub, input int nb, na, nw);
    wq.delete();
    hdr(sub);
    for (int k = 0; k < nb; k++) begin
      wb(8'hC3, k < na);
    end
    i_i2ccp_master.stop();
    chk("stored", 16'(wq.size()), 16'(nw));
    $display("refusal test at %h done", sub);
  endtask : t_refuse
  task automatic t_read;
    hdr(16'hFFFE);
    i_i2ccp_master.start();
    wb(AW | 8'h01, 1'b1);
    for (int k = 0; k < 3; k++) begin
      i_i2ccp_master.byte_x(8'hFF, k == 2, q, a);
      chk("read", 16'(q), (k == 0) ? 16'h005B : 16'h005A);
    end
    i_i2ccp_master.stop();
    $display("burst read done");
  endtask : t_read
  task automatic t_abort;
    wq.delete();
    hdr(16'h0000);
    wb(8'h12, 1'b1);
    for (int k = 0; k < 3; k++) begin
      i_i2ccp_master.bit_x(1'b1, a);
    end
    hdr(16'h0004);
    wb(8'h34, 1'b1);
    i_i2ccp_master.stop();
    chk("abort count", 16'(wq.size()), 16'h0002);
    chk("abort index", 16'(wq[$].index), 16'h0000);
    $display("abort test done");
  endtask : t_abort
  task automatic t_modes;
    chk("mode", 16'(mode), 16'(I2CCP_MODE_I2C));
    repeat (3) begin
      latch <= 1'b0;
      repeat (5) @(posedge clk_sys);
      latch <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
    chk("mode", 16'(mode), 16'(I2CCP_MODE_SPI));
    i_i2ccp_master.start();
    wb(AW, 1'b0);
    i_i2ccp_master.stop();
    rst(1'b1);
    chk("boot", 16'(boot_start), 16'h0001);
    chk("mode", 16'(mode), 16'(I2CCP_MODE_BOOT));
    @(posedge clk_sys);
    #1;
    chk("boot", 16'(boot_start), 16'h0000);
    $display("mode test done");
  endtask : t_modes
  // ****
  // Sequence
  // ****
  initial begin
    rst_n    = 1'b0;
    clk_en   = 1'b1;
    boot_pin = 1'b0;
    latch    = 1'b1;
    sel_lo   = 1'b1;
    sel_hi   = 1'b1;
    rst(1'b0);
    repeat (6) @(posedge clk_sys);
    t_addr();
    t_burst();
    t_refuse(16'h2000, 2, 2, 0);
    t_refuse(16'h8000, 1, 0, 0);
    t_refuse(16'hFFFF, 2, 1, 1);
    t_read();
    t_abort();
    t_modes();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb
